/* evpd_pkg.sv */
// Shared constants for the exception vector priority decoder.
package evpd_pkg;
   // Fixed reset vectors, independent of the programmable base.
   localparam logic [15:0] VEC_RST_PIN = 16'hFFFE;
   localparam logic [15:0] VEC_RST_CLKMON = 16'hFFFC;
   localparam logic [15:0] VEC_RST_WDOG = 16'hFFFA;
   // Low-byte offsets added to the vector base.
   localparam logic [7:0] OFS_TRAP = 8'hF8;
   localparam logic [7:0] OFS_SWI = 8'hF6;
   localparam logic [7:0] OFS_XLVL = 8'hF4;
   localparam logic [7:0] OFS_I_TOP = 8'hF2;
   localparam logic [7:0] OFS_I_LOW = 8'h82;
   localparam logic [7:0] OFS_SPUR = 8'h80;
   // Base upper byte after reset and while background debug runs.
   localparam logic [7:0] BASE_RST = 8'hFF;
   localparam logic [7:0] BASE_DEBUG = 8'hFF;
   // Reset value of the registered vector output.
   localparam logic [15:0] VEC_RST_VAL = 16'h0000;
   // Register byte addresses on the bus.
   localparam int WB_AW = 8;
   localparam logic [WB_AW-1:0] ADR_BASE = 8'h00;
   localparam logic [WB_AW-1:0] ADR_STAT = 8'h04;
   // Status register field positions.
   localparam int STAT_VEC_LSB = 0;
   localparam int STAT_XPEND = 16;
   localparam int STAT_IPEND = 17;
   localparam int STAT_WAKE = 18;
   // Width of an I-level channel index and the largest channel count.
   localparam int IDX_W = 6;
   localparam int MAX_IREQ = 57;
endpackage : evpd_pkg

/* evpd_prio_enc.sv */
// Fixed-priority encoder: the lowest set index wins.
`timescale 1ns/1ps
`default_nettype none
module evpd_prio_enc
   import evpd_pkg::*;
#(
   parameter int N = MAX_IREQ
) (
   input wire logic [N-1:0] req_i, // Qualified request lines.
   output logic any_o, // At least one line is set.
   output logic [IDX_W-1:0] idx_o // Index of the winning line.
);
   logic [N:0] seen; // Set once a lower index has been seen.
   logic [N-1:0] win; // One-hot winner.

   // The index port must be able to name every channel.
   generate
      if (N < 1 || N > (1 << IDX_W)) begin : g_bad_n
         $error("N does not fit the index width");
      end
   endgenerate

   assign seen[0] = 1'b0;

   // One stage per channel; a stage wins only if nothing below it did.
   genvar k;
   generate
      for (k = 0; k < N; k = k + 1) begin : g_chan
         assign seen[k+1] = seen[k] | req_i[k];
         assign win[k] = req_i[k] & ~seen[k];
      end
   endgenerate

   assign any_o = seen[N];

   // Encode the one-hot winner into a binary index.
   always_comb begin
      idx_o = '0;
      for (int j = 0; j < N; j++) begin
         if (win[j]) begin
            idx_o = idx_o | IDX_W'(j);
         end
      end
   end
endmodule // evpd_prio_enc
`default_nettype wire

/* evpd_wb_regs.sv */
// Classic Wishbone slave holding the vector base and reading status.
`timescale 1ns/1ps
`default_nettype none
module evpd_wb_regs
   import evpd_pkg::*;
(
   input wire logic clk_i, // Core clock.
   input wire logic rst_i, // Synchronous reset, active high.
   input wire logic ce_i, // Clock enable; low freezes all state.
   input wire logic [WB_AW-1:0] adr_i, // Byte address.
   input wire logic [31:0] dat_i, // Write data.
   input wire logic [3:0] sel_i, // Byte lane selects.
   input wire logic we_i, // Write strobe qualifier.
   input wire logic stb_i, // Strobe.
   input wire logic cyc_i, // Cycle.
   input wire logic [31:0] stat_i, // Status word to read back.
   output logic [31:0] dat_o, // Read data, registered.
   output logic ack_o, // Acknowledge, registered.
   output logic [7:0] base_o // Vector base upper byte.
);
   typedef struct packed {
      logic [7:0] base; // Vector base upper byte.
      logic ack; // Acknowledge pulse.
      logic [31:0] dat; // Read data.
   } evpd_wb_st_t;

   evpd_wb_st_t st_r; // Registered state.
   evpd_wb_st_t st_nxt; // Next state.
   logic take; // A new request is taken this cycle.

   // One wait-free answer: ack one cycle after the request, then drop.
   always_comb begin
      st_nxt = st_r;
      take = cyc_i & stb_i & ~st_r.ack;
      st_nxt.ack = take;
      if (take) begin
         st_nxt.dat = '0;
         case (adr_i)
            ADR_BASE: begin
               // Readable and writable at any time.
               st_nxt.dat = {24'h000000, st_r.base};
               if (we_i && sel_i[0]) begin
                  st_nxt.base = dat_i[7:0];
               end
            end
            ADR_STAT: begin
               st_nxt.dat = stat_i;
            end
            default: begin
               // Unmapped addresses still answer, reading zero.
               st_nxt.dat = '0;
            end
         endcase
      end
   end

   // Register the state; reset places the vectors at the top.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_r <= '{base: BASE_RST, ack: 1'b0, dat: '0};
      end else if (ce_i) begin
         st_r <= st_nxt;
      end
   end

   assign dat_o = st_r.dat;
   assign ack_o = st_r.ack;
   assign base_o = st_r.base;

   chk_base_reset: assert property (@(posedge clk_i)
      rst_i |=> (base_o == BASE_RST))
      else $error("vector base not all ones after reset");
   chk_base_write: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (ce_i && take && we_i && sel_i[0] && adr_i == ADR_BASE)
      |=> (base_o == $past(dat_i[7:0])))
      else $error("vector base write not stored");
endmodule // evpd_wb_regs
`default_nettype wire

/* evpd_decoder.sv */
// Exception vector priority decoder top with register slave.
//
// Overview of operation
// - Vector base is register byte, low zero.
// - Reset loads the base byte with ones.
// - Reset vectors are fixed, ignore base.
// - Debug active forces base byte to ones.
// - Highest vector address wins among pending.
// - I-level needs enable, clear mask, none higher.
// - Non I-level always outrank I-level; a masked X-level does not here.
// - Unmasked X-level preempts I-level routines.
// - Vector chosen when core asks for it.
// - No active request gives spurious vector.
// - Pin, clock monitor, watchdog reset vectors.
// - Trap F8, software or debug F6.
// - Single X-level request at F4.
// - Highest I-level source at F2.
// - Peripheral sources F0 down to 82.
// - Qualifying request wakes core while gated.
// - Base register readable, writable any time.
// - I mask blocks I-level wake-up.
// - X-level wakes despite its mask set.
//
// Added by the designer: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module evpd_decoder
   import evpd_pkg::*;
#(
   parameter int NUM_IREQ = MAX_IREQ // I-level channel count.
) (
   input wire logic MCLK_I, // Core clock, 40 MHz.
   input wire logic RST_I, // Synchronous reset, active high.
   input wire logic CE_I, // Clock enable; low freezes all state.
   input wire logic [WB_AW-1:0] ADR_I, // Wishbone byte address.
   input wire logic [31:0] DAT_I, // Wishbone write data.
   input wire logic [3:0] SEL_I, // Wishbone byte selects.
   input wire logic WE_I, // Wishbone write enable.
   input wire logic STB_I, // Wishbone strobe.
   input wire logic CYC_I, // Wishbone cycle.
   output logic [31:0] DAT_O, // Wishbone read data.
   output logic ACK_O, // Wishbone acknowledge.
   input wire logic RST_PIN_REQ_I, // Pin, power-on, address, voltage.
   input wire logic RST_CLKMON_REQ_I, // Clock monitor reset cause.
   input wire logic RST_WDOG_REQ_I, // Watchdog timer reset cause.
   input wire logic TRAP_REQ_I, // Unimplemented opcode trap.
   input wire logic SOFTWARE_EXCEPTION_REQUEST_I, // Software or debug.
   input wire logic X_LEVEL_REQ_I, // Die link error or x-level pin.
   input wire logic [NUM_IREQ-1:0] I_REQ_I, // I-level, 0 is highest.
   input wire logic [NUM_IREQ-1:0] I_EN_I, // Peripheral-local enables.
   input wire logic I_MASK_I, // I mask of core condition flags.
   input wire logic X_MASK_I, // X mask of core condition flags.
   input wire logic BACKGROUND_DEBUG_STATE_I, // Debug firmware runs.
   input wire logic VEC_REQ_I, // Core asks for a vector.
   output logic [15:0] VEC_ADDR_O, // Vector address, registered.
   output logic VEC_VALID_O, // Vector answer marker.
   output logic WAKE_O // Wake request to a gated core.
);
   // Refuse channel counts the vector window cannot hold.
   generate
      if (NUM_IREQ < 1 || NUM_IREQ > MAX_IREQ) begin : g_bad_count
         $error("NUM_IREQ must lie between 1 and the channel maximum");
      end
   endgenerate

   // The encoder index must be wide enough for every channel.
   generate
      if (NUM_IREQ > (1 << IDX_W)) begin : g_bad_index
         $error("NUM_IREQ exceeds the channel index width");
      end
   endgenerate

   // All decoder state in one record.
   typedef struct packed {
      logic [15:0] vec; // Last vector handed to the core.
      logic valid; // Answer marker.
   } evpd_st_t;

   evpd_st_t st_r; // Registered state.
   evpd_st_t st_nxt; // Next state.

   logic [7:0] base_reg; // Programmed base byte from the slave.
   logic [7:0] base_hi; // Upper byte actually used.
   logic [NUM_IREQ-1:0] i_act; // Requests with their local enable.
   logic i_any; // Some enabled I-level request exists.
   logic [IDX_W-1:0] i_idx; // Winning I-level channel.
   logic [7:0] i_ofs; // Low byte of the winning I-level vector.
   logic x_pend; // X-level request that may be serviced.
   logic hi_pend; // Software, trap or serviceable X pending.
   logic rst_any; // Any reset cause pending.
   logic i_qual; // I-level request that may be serviced.
   logic vec_take; // Core vector request sampled this edge.
   logic [15:0] vec_sel; // Combinational vector choice.
   logic [31:0] stat_word; // Status word for the bus.

   // Only enabled sources compete at all.
   assign i_act = I_REQ_I & I_EN_I;

   // Fixed priority among I-level channels, lowest index highest.
   // A ripple chain is slow for many channels but needs no wide tree.
   evpd_prio_enc #(
      .N(NUM_IREQ)
   ) u_prio (
      .req_i(i_act),
      .any_o(i_any),
      .idx_o(i_idx)
   );

   // Channel 0 sits at F2, each next channel two bytes lower.
   // The count check keeps the subtraction from wrapping below 82.
   assign i_ofs = OFS_I_TOP - {1'b0, i_idx, 1'b0};

   // Masked X-level is not pending for service, only for wake-up.
   // A masked X-level request cannot be served, so it must not hold
   // off the I-level requests either; it only reaches the wake path.
   assign x_pend = X_LEVEL_REQ_I & ~X_MASK_I;
   assign hi_pend = TRAP_REQ_I | SOFTWARE_EXCEPTION_REQUEST_I | x_pend;
   assign i_qual = i_any & ~I_MASK_I & ~hi_pend;
   assign rst_any = RST_PIN_REQ_I | RST_CLKMON_REQ_I | RST_WDOG_REQ_I;

   // Debug firmware must find every vector at the top page.
   // The override acts at once, so debug entry needs no base write.
   assign base_hi = BACKGROUND_DEBUG_STATE_I ? BASE_DEBUG : base_reg;

   // The decision uses the requests present now, so a later higher
   // request replaces the one that made the core ask.
   always_comb begin
      // Resets first, at fixed addresses regardless of base.
      if (RST_PIN_REQ_I) begin
         vec_sel = VEC_RST_PIN;
      end else if (RST_CLKMON_REQ_I) begin
         vec_sel = VEC_RST_CLKMON;
      end else if (RST_WDOG_REQ_I) begin
         vec_sel = VEC_RST_WDOG;
      end else if (TRAP_REQ_I) begin
         vec_sel = {base_hi, OFS_TRAP};
      end else if (SOFTWARE_EXCEPTION_REQUEST_I) begin
         vec_sel = {base_hi, OFS_SWI};
      end else if (x_pend) begin
         // Non I-level sources rank above any I-level, except a masked X-level.
         vec_sel = {base_hi, OFS_XLVL};
      end else if (i_qual) begin
         vec_sel = {base_hi, i_ofs};
      end else begin
         // The request vanished before the core asked.
         vec_sel = {base_hi, OFS_SPUR};
      end
   end

   // Capture the vector on the edge the request is sampled.
   // Sampling the level lets a held request be answered again.
   assign vec_take = VEC_REQ_I;

   // Next-state logic: a fresh vector on each request.
   // The marker follows the request, so a held request keeps it high.
   always_comb begin
      st_nxt = st_r;
      st_nxt.valid = vec_take;
      if (vec_take) begin
         st_nxt.vec = vec_sel;
      end
   end

   // State register; a low clock enable freezes it, standing in for
   // the gated clock of the low-power modes.
   // Reset wins over a low enable so a frozen core still restarts.
   always_ff @(posedge MCLK_I) begin
      if (RST_I) begin
         st_r <= '{vec: VEC_RST_VAL, valid: 1'b0};
      end else if (CE_I) begin
         st_r <= st_nxt;
      end
   end

   assign VEC_ADDR_O = st_r.vec;
   assign VEC_VALID_O = st_r.valid;

   // The wake path is left combinational on purpose: with the clock
   // stopped no flip-flop could carry it. X-level wakes even when its
   // mask is set; the core then resumes without its routine.
   // Limitation: a source that drops before the core wakes is lost,
   // which is why the sources must hold their requests.
   assign WAKE_O = rst_any | X_LEVEL_REQ_I
      | (i_any & ~I_MASK_I);

   // Status for software: last vector and pending summary.
   // Bits above the wake flag read zero, so software may test the
   // word against a mask without clearing spare bits first.
   always_comb begin
      stat_word = '0;
      stat_word[STAT_VEC_LSB +: 16] = st_r.vec;
      stat_word[STAT_XPEND] = x_pend;
      stat_word[STAT_IPEND] = i_qual;
      stat_word[STAT_WAKE] = WAKE_O;
   end

   // Register slave holding the base byte.
   evpd_wb_regs u_regs (
      .clk_i(MCLK_I),
      .rst_i(RST_I),
      .ce_i(CE_I),
      .adr_i(ADR_I),
      .dat_i(DAT_I),
      .sel_i(SEL_I),
      .we_i(WE_I),
      .stb_i(STB_I),
      .cyc_i(CYC_I),
      .stat_i(stat_word),
      .dat_o(DAT_O),
      .ack_o(ACK_O),
      .base_o(base_reg)
   );

   // Checks on the decoder, all in the core clock domain.
   default clocking cb @(posedge MCLK_I);
   endclocking
   default disable iff (RST_I);

   // A request taken on an enabled edge.
   sequence s_take;
      CE_I && VEC_REQ_I;
   endsequence

   // A request taken with no reset cause pending.
   sequence s_take_norst;
      CE_I && VEC_REQ_I && !rst_any;
   endsequence

   // An edge on which no vector is taken.
   sequence s_no_take;
      !(CE_I && VEC_REQ_I);
   endsequence

   // A request taken with no reset and no higher request pending.
   sequence s_take_ilevel;
      s_take_norst ##0 !hi_pend;
   endsequence

   chk_valid_after_take: assert property (
      s_take |=> VEC_VALID_O)
      else $error("vector marker missing after request");

   // Reset vectors, in their fixed order.
   chk_pin_reset_vec: assert property (
      s_take ##0 RST_PIN_REQ_I |=> VEC_ADDR_O == VEC_RST_PIN)
      else $error("pin reset vector wrong");
   chk_reset_order: assert property (
      s_take ##0 (!RST_PIN_REQ_I && RST_CLKMON_REQ_I)
      |=> VEC_ADDR_O == VEC_RST_CLKMON)
      else $error("clock monitor vector wrong");
   chk_wdog_vec: assert property (
      s_take ##0 (!RST_PIN_REQ_I && !RST_CLKMON_REQ_I && RST_WDOG_REQ_I)
      |=> VEC_ADDR_O == VEC_RST_WDOG)
      else $error("watchdog vector wrong");

   // Base byte: programmed, or forced while debug runs.
   chk_base_upper: assert property (
      s_take_norst ##0 !BACKGROUND_DEBUG_STATE_I
      |=> VEC_ADDR_O[15:8] == $past(base_reg) && VEC_ADDR_O[0] == 1'b0)
      else $error("vector base byte not used");
   chk_debug_base: assert property (
      s_take_norst ##0 BACKGROUND_DEBUG_STATE_I
      |=> VEC_ADDR_O[15:8] == BASE_DEBUG)
      else $error("debug base not forced");

   // Vectors of the requests that outrank the I-level ones.
   chk_trap_vec: assert property (
      s_take_norst ##0 TRAP_REQ_I |=> VEC_ADDR_O[7:0] == OFS_TRAP)
      else $error("trap vector wrong");
   chk_x_preempt: assert property (
      s_take_norst ##0 (!TRAP_REQ_I && !SOFTWARE_EXCEPTION_REQUEST_I
      && X_LEVEL_REQ_I && !X_MASK_I) |=> VEC_ADDR_O[7:0] == OFS_XLVL)
      else $error("x-level vector wrong");

   // I-level qualification by the mask flag.
   chk_imask_spur: assert property (
      s_take_norst ##0 (!hi_pend && I_MASK_I)
      |=> VEC_ADDR_O[7:0] == OFS_SPUR)
      else $error("masked I-level request was served");
   chk_top_ilevel: assert property (
      s_take_norst ##0 (!hi_pend && !I_MASK_I && i_act[0])
      |=> VEC_ADDR_O[7:0] == OFS_I_TOP)
      else $error("top I-level vector wrong");

   // Wake path, which must work with the state frozen.
   chk_wake_x: assert property (
      X_LEVEL_REQ_I |-> WAKE_O)
      else $error("x-level did not wake");
   chk_wake_imask: assert property (
      (I_MASK_I && !X_LEVEL_REQ_I && !rst_any) |-> !WAKE_O)
      else $error("masked I-level woke the core");

   // The answer marker drops on the first enabled edge without a request,
   // the vector holds until the next request.
   chk_valid_drop: assert property (
      (CE_I && !VEC_REQ_I) |=> !VEC_VALID_O)
      else $error("vector marker stayed high");

   chk_vec_hold: assert property (
      s_no_take |=> $stable(VEC_ADDR_O))
      else $error("vector changed without a request");

   // A low clock enable stands for the gated clock: nothing may move.
   chk_freeze_valid: assert property (
      !CE_I |=> $stable(VEC_VALID_O))
      else $error("marker moved while frozen");

   // Reset causes land on the fixed top vectors, base or debug aside.
   chk_reset_fixed: assert property (
      s_take ##0 rst_any
      |=> VEC_ADDR_O inside {VEC_RST_PIN, VEC_RST_CLKMON, VEC_RST_WDOG})
      else $error("reset vector followed the base");

   // Software request below the trap.
   chk_sw_vec: assert property (
      s_take_norst ##0 (!TRAP_REQ_I && SOFTWARE_EXCEPTION_REQUEST_I)
      |=> VEC_ADDR_O[7:0] == OFS_SWI)
      else $error("software vector wrong");

   // Any trap, software or open X request keeps the I-level range out.
   chk_nonmask_rank: assert property (
      s_take_norst ##0 hi_pend |=> VEC_ADDR_O[7:0] >= OFS_XLVL)
      else $error("I-level vector beat a higher request");

   // Nothing left to serve gives the spurious vector.
   chk_spur_none: assert property (
      s_take_ilevel ##0 (i_act == '0) |=> VEC_ADDR_O[7:0] == OFS_SPUR)
      else $error("spurious vector missing");

   // A served I-level vector is even and inside its window.
   chk_ilevel_range: assert property (
      s_take_ilevel ##0 (!I_MASK_I && i_act != '0)
      |=> (VEC_ADDR_O[7:0] <= OFS_I_TOP) && (VEC_ADDR_O[7:0] >= OFS_I_LOW)
      && !VEC_ADDR_O[0])
      else $error("I-level vector outside its window");

   // An open, unmasked I-level request wakes the core.
   chk_wake_ilevel: assert property (
      (((I_REQ_I & I_EN_I) != '0) && !I_MASK_I) |-> WAKE_O)
      else $error("open I-level request did not wake");

   // Trap and software requests never wake a gated core on their own.
   chk_wake_quiet: assert property (
      (!rst_any && !X_LEVEL_REQ_I && i_act == '0) |-> !WAKE_O)
      else $error("wake without a request");
endmodule // evpd_decoder
`default_nettype wire

/* evpd_core_model.sv */
// Behavioural processor core that asks the decoder for exception vectors.
`timescale 1ns/1ps
`default_nettype none
module evpd_core_model (
   input wire logic clk_i, // Core clock.
   input wire logic vec_valid_i, // Answer marker from the decoder.
   input wire logic [15:0] vec_addr_i, // Vector from the decoder.
   output logic vec_req_o // Vector request to the decoder.
);
   // The request line rests low until the bench asks for a vector.
   initial vec_req_o = 1'b0;

   // One request pulse after an idle gap, so both prompt and slow cores
   // are seen; the vector is taken only at the edge where the marker is
   // high, never earlier, because the address may still be the old one.
   task automatic ask(input int gap, output logic [15:0] vec,
                      output logic ok);
      ok = 1'b0;
      vec = 16'h0000;
      repeat (gap) @(posedge clk_i);
      @(posedge clk_i);
      vec_req_o <= 1'b1;
      @(posedge clk_i);
      vec_req_o <= 1'b0;
      for (int i = 0; i < 8 && !ok; i++) begin
         @(posedge clk_i);
         if (vec_valid_i === 1'b1) begin
            vec = vec_addr_i;
            ok = 1'b1;
         end
      end
   endtask
endmodule // evpd_core_model
`default_nettype wire

/* tb_top.sv */
// Self-checking bench for the exception vector priority decoder.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import evpd_pkg::*;
   localparam int NI = 8; // Small channel count keeps the tables short.
   logic mclk = 1'b0; // Core clock.
   logic rst = 1'b1, ce = 1'b1, we = 1'b0, stb = 1'b0, cyc = 1'b0;
   logic [7:0] adr = 8'h00; // Bus address.
   logic [31:0] dat_w = 32'h0, dat_r; // Bus data.
   logic [3:0] sel = 4'h0; // Byte selects.
   logic ack, vreq, vvalid, wake; // Design answers.
   logic [5:0] src = 6'h00; // Pin, clkmon, wdog, trap, sw, x-level.
   logic [NI-1:0] ireq = '0, ien = '0; // I-level requests and enables.
   logic imask = 1'b0, xmask = 1'b0, dbg = 1'b0; // Core flags.
   logic [15:0] vaddr; // Registered vector.
   logic [7:0] base_sw = BASE_RST; // Bench copy of the base byte.
   logic [31:0] q; // Last bus read.
   int n_mismatch = 0, num_checks = 0;
   integer seed = 32'h0ED8;

   always #12.5 mclk = ~mclk;

   evpd_decoder #(.NUM_IREQ(NI)) evpd_decoder_i (.MCLK_I(mclk), .RST_I(rst),
      .CE_I(ce), .ADR_I(adr), .DAT_I(dat_w), .SEL_I(sel), .WE_I(we),
      .STB_I(stb), .CYC_I(cyc), .DAT_O(dat_r), .ACK_O(ack),
      .RST_PIN_REQ_I(src[5]), .RST_CLKMON_REQ_I(src[4]),
      .RST_WDOG_REQ_I(src[3]), .TRAP_REQ_I(src[2]),
      .SOFTWARE_EXCEPTION_REQUEST_I(src[1]), .X_LEVEL_REQ_I(src[0]),
      .I_REQ_I(ireq), .I_EN_I(ien), .I_MASK_I(imask), .X_MASK_I(xmask),
      .BACKGROUND_DEBUG_STATE_I(dbg), .VEC_REQ_I(vreq),
      .VEC_ADDR_O(vaddr), .VEC_VALID_O(vvalid), .WAKE_O(wake));
   evpd_core_model evpd_core_model_i (.clk_i(mclk), .vec_valid_i(vvalid),
      .vec_addr_i(vaddr), .vec_req_o(vreq));

   // Counts every comparison and reports each difference at once.
   task automatic check(input logic [31:0] seen, exp, input string msg);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: %s seen %h expected %h", $time, msg,
                  seen, exp);
      end
   endtask

   // Classic single cycle; the answer is taken only at the ack edge.
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
      q = 32'h0;
      @(posedge mclk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat_w <= d;
      sel <= 4'hF;
      // Wait as long as the slave needs; only the watchdog ends a hang.
      do begin
         @(posedge mclk);
      end while (ack !== 1'b1);
      q = dat_r;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask

   // Expected vector from the documented ranking.
   function automatic logic [15:0] exp_vec();
      logic [7:0] b;
      logic [NI-1:0] p;
      b = dbg ? BASE_DEBUG : base_sw;
      p = ireq & ien;
      if (src[5]) return VEC_RST_PIN;
      if (src[4]) return VEC_RST_CLKMON;
      if (src[3]) return VEC_RST_WDOG;
      if (src[2]) return {b, OFS_TRAP};
      if (src[1]) return {b, OFS_SWI};
      if (src[0] && !xmask) return {b, OFS_XLVL};
      if (!imask) begin
         for (int k = 0; k < NI; k++) begin
            if (p[k]) return {b, OFS_I_TOP - 8'(2 * k)};
         end
      end
      return {b, OFS_SPUR};
   endfunction

   // Sources change at an edge and then hold until the vector is taken.
   task automatic apply(input logic [5:0] s, input logic [NI-1:0] r, e,
                        input logic im, xm, db);
      @(posedge mclk);
      src <= s;
      ireq <= r;
      ien <= e;
      imask <= im;
      xmask <= xm;
      dbg <= db;
   endtask

   // Checks the wake line, then asks for a vector and compares it.
   task automatic vec_test(input string nm);
      logic [15:0] v;
      logic ok;
      logic w;
      @(posedge mclk);
      w = |src[5:3] | src[0] | ((|(ireq & ien)) & !imask);
      check(wake, w, "wake");
      evpd_core_model_i.ask($unsigned($random(seed)) % 3, v, ok);
      check(ok, 1'b1, "no answer");
      check(v, exp_vec(), nm);
      $display("test %s done", nm);
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Cuts a hang short well beyond the few hundred cycles needed.
   initial begin
      #(25 * 20000);
      n_mismatch++;
      report_and_stop();
   end

   initial begin
      logic [15:0] gv; // Vector seen while frozen.
      logic gok; // Answer flag while frozen.
      repeat (5) @(posedge mclk);
      rst <= 1'b0;
      check(vaddr, VEC_RST_VAL, "reset vector");
      wb(1'b0, ADR_BASE, 32'h0);
      check(q, {24'h0, BASE_RST}, "base after reset");
      wb(1'b0, 8'h08, 32'h0);
      check(q, 32'h0, "unmapped read");
      base_sw = 8'h3C;
      wb(1'b1, ADR_BASE, {24'h0, base_sw});
      wb(1'b0, ADR_BASE, 32'h0);
      check(q, {24'h0, base_sw}, "base readback");
      // Peel the highest source off one at a time.
      for (int k = 0; k < 7; k++) begin
         apply(6'h3F >> k, '1, '1, 1'b0, 1'b0, 1'b0);
         vec_test("ladder");
      end
      apply(6'h00, 8'h80, 8'hFF, 1'b0, 1'b0, 1'b0);
      vec_test("lowest peripheral");
      apply(6'h00, 8'h80, 8'h7F, 1'b0, 1'b0, 1'b0);
      vec_test("disabled source");
      apply(6'h01, 8'h01, 8'h01, 1'b1, 1'b1, 1'b0);
      vec_test("both masked");
      apply(6'h01, 8'h01, 8'h01, 1'b0, 1'b1, 1'b0);
      vec_test("masked x");
      apply(6'h08, 8'h00, 8'h00, 1'b0, 1'b0, 1'b1);
      vec_test("debug reset");
      apply(6'h02, 8'h00, 8'h00, 1'b0, 1'b0, 1'b1);
      vec_test("debug sw");
      // Frozen clock: no answer, vector kept, yet a request still wakes.
      @(posedge mclk);
      ce <= 1'b0;
      apply(6'h00, 8'h02, 8'h02, 1'b0, 1'b0, 1'b0);
      @(posedge mclk);
      check(wake, 1'b1, "gated wake");
      evpd_core_model_i.ask(0, gv, gok);
      check(gok, 1'b0, "frozen answer");
      check(vaddr, {BASE_DEBUG, OFS_SWI}, "frozen vector");
      ce <= 1'b1;
      $display("test gated done");
      wb(1'b0, ADR_STAT, 32'h0);
      check(q, {13'h0000, 3'b110, BASE_DEBUG, OFS_SWI}, "status");
      // Random mix with occasional new base bytes.
      for (int n = 0; n < 60; n++) begin
         if (n % 10 == 0) begin
            base_sw = 8'($random(seed));
            wb(1'b1, ADR_BASE, {24'h0, base_sw});
            wb(1'b0, ADR_BASE, 32'h0);
            check(q, {24'h0, base_sw}, "random base");
         end
         apply(6'($random(seed) & $random(seed) & $random(seed)),
               NI'($random(seed)), NI'($random(seed)), 1'($random(seed)),
               1'($random(seed)), ($random(seed) & 7) == 0);
         vec_test("random");
      end
      // A reset in mid-run brings the base byte back.
      @(posedge mclk);
      rst <= 1'b1;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      base_sw = BASE_RST;
      check(vaddr, VEC_RST_VAL, "vector after reset");
      check(vvalid, 1'b0, "marker after reset");
      wb(1'b0, ADR_BASE, 32'h0);
      check(q, {24'h0, BASE_RST}, "base after reset");
      report_and_stop();
   end
endmodule // tb_top
`default_nettype wire
